// file: i2cs_pkg.sv
package i2cs_pkg;
  // register indexes on the plain register port
  localparam logic [2:0] REG_STATUS = 3'h0;
  localparam logic [2:0] REG_CTRL1 = 3'h1;
  localparam logic [2:0] REG_CTRL2 = 3'h2;
  localparam logic [2:0] REG_BUFFER = 3'h3;
  localparam logic [2:0] REG_ADDRESS = 3'h4;
  // serial_status fields
  localparam int ST_SLEW = 7;
  localparam int ST_SMBUS = 6;
  // serial_control_two fields
  localparam int C2_GENERAL_CALL_ENABLE = 7;
  localparam int C2_ACKNOWLEDGE_STATUS = 6;
  localparam int C2_ACKNOWLEDGE_DATA = 5;
  localparam int C2_ACKNOWLEDGE_SEQUENCE_ENABLE = 4;
  localparam int C2_RECEIVE_ENABLE = 3;
  localparam int C2_PEN = 2;
  localparam int C2_REPEATED_START_ENABLE = 1;
  localparam int C2_SEN = 0;
  // mode_field codes
  localparam logic [3:0] MODE_SLV7 = 4'h6;
  localparam logic [3:0] MODE_SLV10 = 4'h7;
  localparam logic [3:0] MODE_MST = 4'h8;
  localparam logic [3:0] MODE_FWMST = 4'hb;
  localparam logic [3:0] MODE_SLV7_SP = 4'he;
  localparam logic [3:0] MODE_SLV10_SP = 4'hf;
  // reset values and fixed byte patterns
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
  localparam logic [7:0] MASK_RW_ONLY = 8'h01;
  // bit counts: last bit index of each transfer kind, edges per byte
  localparam logic [3:0] LAST_TX = 4'h8;
  localparam logic [3:0] LAST_RX = 4'h7;
  localparam logic [3:0] LAST_ACK = 4'h0;
  localparam logic [3:0] BYTE_EDGES = 4'h8;
  // register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } i2cs_bus_req_type;
  typedef enum logic [2:0] {
    M_IDLE = 3'b000, M_START = 3'b001, M_XFER = 3'b011,
    M_RSTART = 3'b010, M_STOP = 3'b110
  } i2cs_mst_state_type;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ADDR = 3'b001, S_ADDR_ACK = 3'b011, S_RX = 3'b010,
    S_RX_ACK = 3'b110, S_TX = 3'b111, S_TX_ACK = 3'b101
  } i2cs_slv_state_type;
  typedef enum logic [1:0] {
    XFER_TX = 2'b00, XFER_RX = 2'b01, XFER_ACK = 2'b11
  } i2cs_xfer_type;
endpackage

// file: i2cs_port.sv
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module i2cs_port
  import i2cs_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire i2cs_bus_req_type bus_in,
  output logic [7:0] rdata_out,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic port_irq_out,
  output logic pins_owned_out,
  output logic slew_ctrl_out,
  output logic smbus_thr_out
);
  i2cs_mst_state_type mst_state;
  i2cs_slv_state_type slv_state;
  i2cs_xfer_type kind_reg;
  logic slew_reg, smbus_reg, data_addr_reg, stop_seen_reg, start_seen_reg;
  logic rw_reg, ua_reg, bf_reg, write_collision_flag_reg, ov_reg, en_reg, ckp_reg;
  logic [3:0] mode_reg;
  logic [7:0] c2_reg, buf_reg, sr_reg, add_reg, rdata_reg;
  logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
  logic scl_low_reg, sda_low_reg, irq_reg, pin_level_reg;
  logic hold_reg, slv_ack_reg, low_wait_reg, ten_full_reg;
  logic [1:0] q_reg;
  logic [3:0] bit_cnt_reg, sbit_reg;
  logic [6:0] brg_cnt_reg;
  logic is_master, slave_on, ten_bit, sp_irq, mst_busy, mst_active;
  logic wr_buf, rd_buf, slv_shifting, stall, brg_tick, out_bit;
  logic [3:0] last_bit;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic hit_gc, hit7, hit_hi, hit_lo, slv_hit, rx_free;

  // masked compare: a set mask bit makes that position a don't-care
  function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] own,
                                    input logic [7:0] msk);
    addr_hit = ((rx ^ own) & ~msk) == 8'h00;
  endfunction

  // mode decode
  assign is_master = en_reg && (mode_reg == MODE_MST || mode_reg == MODE_FWMST);
  assign slave_on = en_reg && (mode_reg == MODE_SLV7 || mode_reg == MODE_SLV10 ||
                    mode_reg == MODE_SLV7_SP || mode_reg == MODE_SLV10_SP);
  assign ten_bit = mode_reg[0];
  assign sp_irq = mode_reg == MODE_SLV7_SP || mode_reg == MODE_SLV10_SP;
  assign mst_busy = mst_state != M_IDLE;
  // any pending sequence bit also counts as busy: no spooling of requests
  assign mst_active = mst_busy || (|c2_reg[C2_ACKNOWLEDGE_SEQUENCE_ENABLE:C2_SEN]) || rw_reg;
  assign wr_buf = bus_in.wr && bus_in.addr == REG_BUFFER;
  assign rd_buf = bus_in.rd && bus_in.addr == REG_BUFFER;
  assign slv_shifting = (slv_state == S_TX && sbit_reg != 4'h0) || slv_state == S_TX_ACK;
  assign rx_free = !bf_reg && !ov_reg;

  // bus condition detection on synchronised lines only
  assign scl_rise = scl_s2 && !scl_s3;
  assign scl_fall = !scl_s2 && scl_s3;
  assign start_det = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  assign stop_det = scl_s2 && scl_s3 && !sda_s3 && sda_s2;

  // address matching
  assign hit_gc = c2_reg[C2_GENERAL_CALL_ENABLE] && sr_reg == GEN_CALL_ADDR;
  assign hit7 = addr_hit(sr_reg, add_reg, {2'b00, c2_reg[5:1], 1'b1});
  assign hit_hi = sr_reg[7:3] == TEN_BIT_PREFIX && addr_hit(sr_reg, add_reg, MASK_RW_ONLY);
  assign hit_lo = addr_hit(sr_reg, add_reg, {2'b00, c2_reg[5:1], c2_reg[1]});
  always_comb
  begin
    if (!ten_bit)
      slv_hit = hit_gc || hit7;
    else if (low_wait_reg)
      slv_hit = hit_gc || hit_lo;
    else
      slv_hit = hit_gc || (hit_hi && (!sr_reg[0] || ten_full_reg));
  end

  // master bit value and length of each transfer kind
  always_comb
  begin
    unique case (kind_reg)
      XFER_TX:
      begin
        out_bit = bit_cnt_reg == LAST_TX ? 1'b1 : sr_reg[7];
        last_bit = LAST_TX;
      end
      XFER_RX:
      begin
        out_bit = 1'b1;
        last_bit = LAST_RX;
      end
      default:
      begin
        out_bit = c2_reg[C2_ACKNOWLEDGE_DATA];
        last_bit = LAST_ACK;
      end
    endcase
  end

  // a slave holding the clock low stalls the baud generator
  assign stall = mst_busy && !scl_low_reg && !scl_s2;
  assign brg_tick = mst_busy && !stall && brg_cnt_reg == 7'h00;

  // two-stage pin synchronisers, third stage for edge detection
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
    end
    else
    begin
      {scl_s3, scl_s2, scl_s1} <= {scl_s2, scl_s1, scl_in};
      {sda_s3, sda_s2, sda_s1} <= {sda_s2, sda_s1, sda_in};
    end
  end

  // baud generator: one quarter bit every reload plus one clocks
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      brg_cnt_reg <= 7'h00;
    else if (!mst_busy || brg_tick)
      brg_cnt_reg <= add_reg[6:0];
    else if (!stall)
      brg_cnt_reg <= brg_cnt_reg - 7'h01;
  end

  // read data stand for exactly one cycle after the strobe
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_reg <= RESET_BYTE;
    else if (bus_in.rd)
    begin
      case (bus_in.addr)
        REG_STATUS: rdata_reg <= {slew_reg, smbus_reg, data_addr_reg, stop_seen_reg,
                                  start_seen_reg, rw_reg, ua_reg, bf_reg};
        REG_CTRL1: rdata_reg <= {write_collision_flag_reg, ov_reg, en_reg, ckp_reg, mode_reg};
        REG_CTRL2: rdata_reg <= c2_reg;
        REG_BUFFER: rdata_reg <= buf_reg;
        REG_ADDRESS: rdata_reg <= add_reg;
        default: rdata_reg <= RESET_BYTE;
      endcase
    end
    else
      rdata_reg <= RESET_BYTE;
  end

  // main engine; hardware sets come after software writes so sets win
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      {slew_reg, smbus_reg, data_addr_reg, stop_seen_reg, start_seen_reg} <= 5'h00;
      {rw_reg, ua_reg, bf_reg, write_collision_flag_reg, ov_reg, en_reg, ckp_reg} <= 7'h00;
      mode_reg <= 4'h0;
      c2_reg <= RESET_BYTE;
      buf_reg <= RESET_BYTE;
      sr_reg <= RESET_BYTE;
      add_reg <= RESET_BYTE;
      {scl_low_reg, sda_low_reg, irq_reg, pin_level_reg} <= 4'h0;
      {hold_reg, slv_ack_reg, low_wait_reg, ten_full_reg} <= 4'h0;
      mst_state <= M_IDLE;
      slv_state <= S_IDLE;
      kind_reg <= XFER_TX;
      q_reg <= 2'h0;
      bit_cnt_reg <= 4'h0;
      sbit_reg <= 4'h0;
    end
    else
    begin
      irq_reg <= 1'b0;
      pin_level_reg <= 1'b0;
      // software writes
      if (bus_in.wr)
      begin
        case (bus_in.addr)
          REG_STATUS: {slew_reg, smbus_reg} <= bus_in.wdata[7:6];
          REG_CTRL1:
          begin
            {write_collision_flag_reg, ov_reg} <= bus_in.wdata[7:6];
            en_reg <= bus_in.wdata[5];
            ckp_reg <= bus_in.wdata[4];
            mode_reg <= bus_in.wdata[3:0];
          end
          REG_CTRL2:
          begin
            c2_reg[C2_GENERAL_CALL_ENABLE] <= bus_in.wdata[C2_GENERAL_CALL_ENABLE];
            c2_reg[C2_ACKNOWLEDGE_DATA] <= bus_in.wdata[C2_ACKNOWLEDGE_DATA];
            if (!is_master || !mst_active)
              c2_reg[C2_ACKNOWLEDGE_SEQUENCE_ENABLE:C2_SEN] <= bus_in.wdata[C2_ACKNOWLEDGE_SEQUENCE_ENABLE:C2_SEN];
          end
          REG_BUFFER:
          begin
            if ((is_master && mst_active) || (slave_on && slv_shifting))
              write_collision_flag_reg <= 1'b1;
            else
            begin
              buf_reg <= bus_in.wdata;
              sr_reg <= bus_in.wdata;
              bf_reg <= 1'b1;
              if (is_master)
                rw_reg <= 1'b1;
            end
          end
          REG_ADDRESS:
          begin
            add_reg <= bus_in.wdata;
            ua_reg <= 1'b0;
          end
          default: ;
        endcase
      end
      if (rd_buf)
        bf_reg <= 1'b0;
      if (!en_reg)
      begin
        // disabled: pins go back to general use and the engines are cleared
        {scl_low_reg, sda_low_reg} <= 2'b00;
        {start_seen_reg, stop_seen_reg} <= 2'b00;
        {hold_reg, low_wait_reg, ten_full_reg} <= 3'h0;
        mst_state <= M_IDLE;
        slv_state <= S_IDLE;
        q_reg <= 2'h0;
      end
      else
      begin
        if (start_det)
        begin
          start_seen_reg <= 1'b1;
          stop_seen_reg <= 1'b0;
          if (sp_irq)
            irq_reg <= 1'b1;
        end
        if (stop_det)
        begin
          stop_seen_reg <= 1'b1;
          start_seen_reg <= 1'b0;
          if (sp_irq)
            irq_reg <= 1'b1;
        end
        if (is_master)
        begin
          slv_state <= S_IDLE;
          unique case (mst_state)
            M_IDLE:
            begin
              q_reg <= 2'h0;
              bit_cnt_reg <= 4'h0;
              if (c2_reg[C2_SEN])
                mst_state <= M_START;
              else if (c2_reg[C2_REPEATED_START_ENABLE])
                mst_state <= M_RSTART;
              else if (c2_reg[C2_PEN])
                mst_state <= M_STOP;
              else if (c2_reg[C2_RECEIVE_ENABLE])
              begin
                mst_state <= M_XFER;
                kind_reg <= XFER_RX;
              end
              else if (c2_reg[C2_ACKNOWLEDGE_SEQUENCE_ENABLE])
              begin
                mst_state <= M_XFER;
                kind_reg <= XFER_ACK;
              end
              else if (wr_buf && !mst_active)
              begin
                mst_state <= M_XFER;
                kind_reg <= XFER_TX;
              end
            end
            M_START:
              if (brg_tick)
              begin
                q_reg <= q_reg + 2'h1;
                if (q_reg == 2'h0)
                  sda_low_reg <= 1'b1;
                else
                begin
                  scl_low_reg <= 1'b1;
                  c2_reg[C2_SEN] <= 1'b0;
                  irq_reg <= 1'b1;
                  mst_state <= M_IDLE;
                end
              end
            M_RSTART:
              if (brg_tick)
              begin
                q_reg <= q_reg + 2'h1;
                unique case (q_reg)
                  2'h0: sda_low_reg <= 1'b0;
                  2'h1: scl_low_reg <= 1'b0;
                  2'h2: sda_low_reg <= 1'b1;
                  2'h3:
                  begin
                    scl_low_reg <= 1'b1;
                    c2_reg[C2_REPEATED_START_ENABLE] <= 1'b0;
                    irq_reg <= 1'b1;
                    mst_state <= M_IDLE;
                  end
                endcase
              end
            M_STOP:
              if (brg_tick)
              begin
                q_reg <= q_reg + 2'h1;
                if (q_reg == 2'h0)
                  sda_low_reg <= 1'b1;
                else if (q_reg == 2'h1)
                  scl_low_reg <= 1'b0;
                else
                begin
                  sda_low_reg <= 1'b0;
                  c2_reg[C2_PEN] <= 1'b0;
                  irq_reg <= 1'b1;
                  mst_state <= M_IDLE;
                end
              end
            M_XFER:
              if (brg_tick)
              begin
                q_reg <= q_reg + 2'h1;
                unique case (q_reg)
                  2'h0: sda_low_reg <= !out_bit;
                  2'h1: scl_low_reg <= 1'b0;
                  2'h2:
                  begin
                    if (kind_reg == XFER_RX)
                      sr_reg <= {sr_reg[6:0], sda_s2};
                    if (kind_reg == XFER_TX && bit_cnt_reg == LAST_TX)
                      c2_reg[C2_ACKNOWLEDGE_STATUS] <= sda_s2;
                  end
                  2'h3:
                  begin
                    scl_low_reg <= 1'b1;
                    if (kind_reg == XFER_TX)
                      sr_reg <= {sr_reg[6:0], 1'b0};
                    if (bit_cnt_reg != last_bit)
                      bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    else
                    begin
                      sda_low_reg <= 1'b0;
                      irq_reg <= 1'b1;
                      mst_state <= M_IDLE;
                      if (kind_reg == XFER_TX)
                      begin
                        rw_reg <= 1'b0;
                        bf_reg <= 1'b0;
                      end
                      else if (kind_reg == XFER_RX)
                      begin
                        c2_reg[C2_RECEIVE_ENABLE] <= 1'b0;
                        bf_reg <= 1'b1;
                        if (bf_reg)
                          ov_reg <= 1'b1;
                        else
                          buf_reg <= sr_reg;
                      end
                      else
                        c2_reg[C2_ACKNOWLEDGE_SEQUENCE_ENABLE] <= 1'b0;
                    end
                  end
                endcase
              end
            default: mst_state <= M_IDLE;
          endcase
        end
        else if (slave_on)
        begin
          mst_state <= M_IDLE;
          // a stretch ends as soon as software sets the release bit
          if (ckp_reg)
            hold_reg <= 1'b0;
          scl_low_reg <= hold_reg && !ckp_reg;
          if (start_det)
          begin
            slv_state <= S_ADDR;
            sbit_reg <= 4'h0;
            rw_reg <= 1'b0;
            sda_low_reg <= 1'b0;
            hold_reg <= 1'b0;
          end
          else if (stop_det)
          begin
            slv_state <= S_IDLE;
            sbit_reg <= 4'h0;
            rw_reg <= 1'b0;
            sda_low_reg <= 1'b0;
            {hold_reg, low_wait_reg, ten_full_reg} <= 3'h0;
          end
          else
          begin
            unique case (slv_state)
              S_IDLE: sda_low_reg <= 1'b0;
              S_ADDR, S_RX:
              begin
                if (scl_rise)
                begin
                  sr_reg <= {sr_reg[6:0], sda_s2};
                  sbit_reg <= sbit_reg + 4'h1;
                end
                if (scl_fall && sbit_reg == BYTE_EDGES)
                begin
                  sbit_reg <= 4'h0;
                  if (slv_state == S_RX || slv_hit)
                  begin
                    slv_ack_reg <= rx_free;
                    sda_low_reg <= rx_free;
                    data_addr_reg <= slv_state == S_RX;
                    slv_state <= slv_state == S_RX ? S_RX_ACK : S_ADDR_ACK;
                    if (rx_free)
                    begin
                      buf_reg <= sr_reg;
                      bf_reg <= 1'b1;
                    end
                    else if (bf_reg)
                      ov_reg <= 1'b1;
                  end
                  else
                    slv_state <= S_IDLE;
                  if (slv_state == S_ADDR && slv_hit)
                  begin
                    rw_reg <= sr_reg[0] && !(ten_bit && low_wait_reg);
                    if (ten_bit && !hit_gc && low_wait_reg)
                    begin
                      ua_reg <= 1'b1;
                      low_wait_reg <= 1'b0;
                      ten_full_reg <= 1'b1;
                    end
                    else if (ten_bit && !hit_gc && !sr_reg[0])
                    begin
                      ua_reg <= 1'b1;
                      low_wait_reg <= 1'b1;
                    end
                  end
                end
              end
              S_ADDR_ACK, S_RX_ACK:
                if (scl_fall)
                begin
                  sda_low_reg <= 1'b0;
                  irq_reg <= 1'b1;
                  if (slv_state == S_ADDR_ACK && !slv_ack_reg)
                  begin
                    slv_state <= S_IDLE;
                    rw_reg <= 1'b0;
                  end
                  else if (slv_state == S_ADDR_ACK && rw_reg)
                  begin
                    slv_state <= S_TX;
                    ckp_reg <= 1'b0;
                    hold_reg <= 1'b1;
                  end
                  else if (low_wait_reg)
                    slv_state <= S_ADDR;
                  else
                  begin
                    slv_state <= S_RX;
                    if (c2_reg[C2_SEN])
                    begin
                      ckp_reg <= 1'b0;
                      hold_reg <= 1'b1;
                    end
                  end
                end
              S_TX:
              begin
                if (sbit_reg == 4'h0 && !scl_s2)
                  sda_low_reg <= !sr_reg[7];
                if (scl_rise)
                  sbit_reg <= sbit_reg + 4'h1;
                if (scl_fall && sbit_reg == BYTE_EDGES)
                begin
                  sda_low_reg <= 1'b0;
                  bf_reg <= 1'b0;
                  data_addr_reg <= 1'b1;
                  slv_state <= S_TX_ACK;
                end
                else if (scl_fall && sbit_reg != 4'h0)
                begin
                  sda_low_reg <= !sr_reg[6];
                  sr_reg <= {sr_reg[6:0], 1'b0};
                end
              end
              S_TX_ACK:
              begin
                if (scl_rise)
                  slv_ack_reg <= !sda_s2;
                if (scl_fall)
                begin
                  irq_reg <= 1'b1;
                  sbit_reg <= 4'h0;
                  if (slv_ack_reg)
                  begin
                    slv_state <= S_TX;
                    ckp_reg <= 1'b0;
                    hold_reg <= 1'b1;
                  end
                  else
                  begin
                    slv_state <= S_IDLE;
                    rw_reg <= 1'b0;
                  end
                end
              end
              default: slv_state <= S_IDLE;
            endcase
          end
        end
        else
        begin
          // reserved or other-protocol codes leave the pins released
          {scl_low_reg, sda_low_reg} <= 2'b00;
          mst_state <= M_IDLE;
          slv_state <= S_IDLE;
        end
      end
    end
  end

  // open-drain pins: level is always low, enable says when it is pulled
  assign scl_out = pin_level_reg;
  assign sda_out = pin_level_reg;
  assign scl_oe_out = scl_low_reg;
  assign sda_oe_out = sda_low_reg;
  assign port_irq_out = irq_reg;
  assign pins_owned_out = en_reg;
  assign slew_ctrl_out = slew_reg;
  assign smbus_thr_out = smbus_reg;
  assign rdata_out = rdata_reg;
endmodule // i2cs_port

// file: i2cs_port_properties.sv
`timescale 1ns/1ps
module i2cs_port_properties
  import i2cs_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire i2cs_bus_req_type bus_in,
  input wire logic [7:0] rdata_out,
  input wire logic scl_out,
  input wire logic sda_out,
  input wire logic scl_oe_out,
  input wire logic sda_oe_out,
  input wire logic port_irq_out,
  input wire logic pins_owned_out,
  input wire logic slew_ctrl_out,
  input wire logic smbus_thr_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // lines are open drain: only the enables may pull them
  chk_open_drain:
    assert property (!scl_out && !sda_out) else $error("pin driven high");
  chk_pins_follow:
    assert property (bus_in.wr && bus_in.addr == REG_CTRL1 |=>
      pins_owned_out == $past(bus_in.wdata[5])) else $error("pin owner wrong");
  // a disabled port must leave both lines alone
  chk_oe_idle:
    assert property (!pins_owned_out [*3] |-> !scl_oe_out && !sda_oe_out)
      else $error("line pulled while off");
  chk_slew_set:
    assert property (bus_in.wr && bus_in.addr == REG_STATUS |=>
      slew_ctrl_out == $past(bus_in.wdata[7])) else $error("slew wrong");
  chk_thr_set:
    assert property (bus_in.wr && bus_in.addr == REG_STATUS |=>
      smbus_thr_out == $past(bus_in.wdata[6])) else $error("threshold wrong");
  chk_slew_hold:
    assert property (!(bus_in.wr && bus_in.addr == REG_STATUS) |=> $stable(slew_ctrl_out))
      else $error("slew moved");
  chk_status_read:
    assert property (bus_in.rd && bus_in.addr == REG_STATUS |=>
      rdata_out[7:6] == $past({slew_ctrl_out, smbus_thr_out})) else $error("status top");
  chk_irq_pulse:
    assert property (port_irq_out |=> !port_irq_out) else $error("irq too long");
  cover property (port_irq_out);
  cover property (sda_oe_out && !scl_oe_out);
  cover property (bus_in.rd && bus_in.addr == REG_STATUS);
endmodule // i2cs_port_properties

// file: i2cs_peer.sv
`timescale 1ns/1ps
module i2cs_peer
(
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic ack_en_in,
  output logic sda_low_out
);
  int falls = 0;
  initial sda_low_out = 1'b0;
  // a start restarts the count of clock falls
  always @(negedge sda_in)
    if (scl_in) falls = 0;
  // pull data low for the ninth bit only, released on its fall
  always @(negedge scl_in)
  begin
    falls = (falls == 9) ? 1 : falls + 1;
    sda_low_out <= (falls == 9) && ack_en_in;
  end
endmodule // i2cs_peer

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  import i2cs_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  i2cs_bus_req_type bus_in = '0;
  logic [7:0] rdata_out, d, r, st, ak;
  logic scl_oe_out, sda_oe_out, port_irq_out, peer_low, ack_en;
  // the bench plays a second master on the lines for the slave test
  logic tb_scl_low = 1'b0;
  logic tb_sda_low = 1'b0;
  wire scl_w = ~(scl_oe_out | tb_scl_low);
  wire sda_w = ~(sda_oe_out | peer_low | tb_sda_low);
  int errors = 0;
  int compares = 0;
  always #25 clk_in = ~clk_in;
  i2cs_port dut (.clk_in, .rst_in, .bus_in, .rdata_out, .scl_in(scl_w),
    .scl_out(), .scl_oe_out, .sda_in(sda_w), .sda_out(),
    .sda_oe_out, .port_irq_out, .pins_owned_out(), .slew_ctrl_out(), .smbus_thr_out());
  i2cs_peer peer (.scl_in(scl_w), .sda_in(sda_w),
    .ack_en_in(ack_en), .sda_low_out(peer_low));
  function automatic logic [7:0] stx(input logic [4:0] lo);
    return st | {3'b000, lo};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one register cycle, read data caught in the cycle after
  task automatic acc(input logic [2:0] a, input logic [7:0] w, input logic wr);
    @(posedge clk_in);
    bus_in <= '{a, w, wr, ~wr};
    @(posedge clk_in);
    bus_in <= '0;
    #1 r = rdata_out;
  endtask
  task automatic wirq();
    int i = 0;
    while (port_irq_out !== 1'b1 && i < 3000)
    begin
      @(negedge clk_in);
      i++;
    end
    if (i == 3000) errors++;
  endtask
  // one line state held four clocks, well above the two-flop sync lag
  task automatic drv(input logic c, input logic s);
    @(posedge clk_in);
    tb_scl_low <= c;
    tb_sda_low <= s;
    repeat (3) @(posedge clk_in);
  endtask
  // eight bits MSB first, then a released ninth bit whose level is returned
  task automatic sbyte(input logic [7:0] b, output logic [7:0] ack);
    logic [8:0] v;
    v = {b, 1'b1};
    for (int i = 8; i >= 0; i--)
    begin
      drv(1'b1, !v[i]);
      drv(1'b0, !v[i]);
      ack = {7'h00, sda_w};
      drv(1'b1, !v[i]);
    end
  endtask
  task finish_test();
    $display("counts: compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    void'($urandom(7800));
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    d = $urandom;
    acc(REG_ADDRESS, d, 1);
    acc(REG_ADDRESS, 8'h00, 0);
    chk(r, d);
    d = $urandom;
    st = d & 8'hc0;
    acc(REG_STATUS, d, 1);
    acc(REG_STATUS, 8'h00, 0);
    chk(r, st);
    $display("test registers done");
    // quarter bit of two clocks keeps the byte short
    acc(REG_ADDRESS, 8'h01, 1);
    acc(REG_CTRL1, {4'h2, MODE_MST}, 1);
    acc(REG_CTRL2, 8'h01, 1);
    wirq();
    acc(REG_CTRL2, 8'h00, 0);
    chk(r, 8'h00);
    // first byte acknowledged, second refused by the peer
    for (int k = 0; k < 2; k++)
    begin
      ack_en = (k == 0);
      d = $urandom;
      acc(REG_BUFFER, d, 1);
      acc(REG_BUFFER, ~d, 1);
      acc(REG_STATUS, 8'h00, 0);
      chk(r & 8'hdf, stx(5'b01101));
      acc(REG_CTRL1, 8'h00, 0);
      chk(r, {4'ha, MODE_MST});
      acc(REG_CTRL1, {4'h2, MODE_MST}, 1);
      wirq();
      acc(REG_CTRL2, 8'h00, 0);
      chk(r, {1'b0, ~ack_en, 6'h00});
      acc(REG_STATUS, 8'h00, 0);
      chk(r & 8'hdf, stx(5'b01000));
    end
    $display("test transmit done");
    // firmware master: repeated start, a byte in from an idle-high line, then a refusal
    acc(REG_CTRL1, {4'h2, MODE_FWMST}, 1);
    acc(REG_CTRL2, 8'h02, 1);
    wirq();
    acc(REG_CTRL2, 8'h08, 1);
    wirq();
    acc(REG_STATUS, 8'h00, 0);
    chk(r & 8'hdf, stx(5'b01001));
    acc(REG_BUFFER, 8'h00, 0);
    chk(r, 8'hff);
    acc(REG_CTRL2, 8'h30, 1);
    wirq();
    acc(REG_CTRL2, 8'h00, 0);
    chk(r & 8'hbf, 8'h20);
    $display("test receive done");
    acc(REG_CTRL2, 8'h04, 1);
    wirq();
    repeat (4) @(posedge clk_in);
    acc(REG_CTRL2, 8'h00, 0);
    chk(r & 8'hbf, 8'h00);
    acc(REG_STATUS, 8'h00, 0);
    chk(r & 8'hdf, stx(5'b10000));
    acc(REG_CTRL1, 8'h00, 1);
    acc(REG_STATUS, 8'h00, 0);
    chk(r & 8'hdf, st);
    $display("test stop done");
    // 7-bit slave: address then one data byte, both acknowledged
    d = $urandom;
    acc(REG_ADDRESS, d, 1);
    acc(REG_CTRL1, {4'h3, MODE_SLV7}, 1);
    drv(1'b0, 1'b1);
    drv(1'b1, 1'b1);
    sbyte({d[7:1], 1'b0}, ak);
    chk(ak, 8'h00);
    acc(REG_BUFFER, 8'h00, 0);
    chk(r, {d[7:1], 1'b0});
    d = $urandom;
    sbyte(d, ak);
    chk(ak, 8'h00);
    drv(1'b1, 1'b1);
    drv(1'b0, 1'b1);
    drv(1'b0, 1'b0);
    acc(REG_STATUS, 8'h00, 0);
    chk(r, st | 8'h31);
    acc(REG_BUFFER, 8'h00, 0);
    chk(r, d);
    $display("test slave done");
    finish_test();
  end
  initial
  begin
    #1000000;
    errors++;
    finish_test();
  end
endmodule // testbench
bind i2cs_port i2cs_port_properties chk (.clk_in, .rst_in, .bus_in, .rdata_out,
  .scl_out, .sda_out, .scl_oe_out, .sda_oe_out, .port_irq_out, .pins_owned_out,
  .slew_ctrl_out, .smbus_thr_out);
